// ### core/ext_mem_pkg.sv
// constants for the external memory port control block
package ext_mem_pkg;
    localparam logic [15:0] PAGE_ONE_OFS  = 16'hC018;
    localparam logic [15:0] PAGE_TWO_OFS  = 16'hC01A;
    localparam logic [15:0] UPPER_EN_OFS  = 16'hC038;
    localparam logic [15:0] TIMING_OFS    = 16'hC03A;
    localparam logic [15:0] MEMTEST_OFS   = 16'hC03E;
    localparam logic [15:0] STATUS_OFS    = 16'hC040;
    localparam logic [15:0] ZERO16        = 16'h0000;
    localparam logic [15:0] TIMING_RST    = 16'h0000;
    localparam int UPPER_EN_BIT   = 3;
    localparam int RAM_MERGE_BIT  = 13;
    localparam int ROM_MERGE_BIT  = 12;
    localparam int EXT_WIDTH_BIT  = 11;
    localparam int EXT_WAIT_LSB   = 8;
    localparam int ROM_WIDTH_BIT  = 7;
    localparam int ROM_WAIT_LSB   = 4;
    localparam int RAM_WIDTH_BIT  = 3;
    localparam int RAM_WAIT_LSB   = 0;
    localparam int ARB_LSB        = 8;
    localparam int ECHO_BIT       = 0;
    localparam logic [15:0] TIMING_MASK  = 16'h3FFF;
    localparam logic [15:0] UPPER_MASK   = 16'h0008;
    localparam logic [15:0] MEMTEST_MASK = 16'h0701;
    // cpu window for mapped pages
    localparam logic [15:0] PAGE1_BASE   = 16'h8000;
    localparam logic [15:0] PAGE2_BASE   = 16'hA000;
    localparam logic [2:0]  PAGE_TAG     = 3'h4;
    localparam logic [2:0]  PAGE2_TAG    = 3'h5;
    localparam logic [15:0] ROM_BASE     = 16'hC000;
    localparam logic [3:0]  UPPER_IDLE   = 4'hF;
    localparam logic [2:0]  WAIT_ZERO    = 3'h0;
    localparam logic [2:0]  SLOT_ONE     = 3'h1;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_DONE   = 4'b1000
    } mem_state_t;
endpackage

// ### core/external_memory_port_control.sv
// external memory port control: page mapping, selects, widths and wait states
// What this block does
// - arbitration field k makes k of every eight system clocks dead
// - echo bit set drives internal address onto external address pins
// - page register supplies address bits 28..13 for its mapped window
// - cpu window 8000-9FFF drives pins 8..0 with page bits 21..13
// - in sram mode only pins 4..0 carry page bits 17..13
// - extended select asserted low for mapped page accesses
// - upper enable bit 3 is stored but does not free A18..A15; they stay high
// - A18..A15 held high whether or not upper lines are enabled, except when echo is set
// - each wait state lasts one system clock
// - ram merge bit 13 makes ram select follow extended select
// - rom merge bit 12 makes rom select follow extended select
// - extended width bit 11: one is 8-bit, zero is 16-bit
// - extended wait field 10..8 inserts zero to seven waits
// - rom width bit 7, rom waits in bits 6..4
// - ram width bit 3, ram waits in bits 2..0
`timescale 1ns/1ps
`default_nettype none
module external_memory_port_control
    import ext_mem_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [15:0] wb_dat_i,
    output logic      [15:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [1:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic        sram_mode_i,
    input  wire logic        cpu_req_i,
    input  wire logic        cpu_we_i,
    input  wire logic [15:0] cpu_adr_i,
    input  wire logic [15:0] cpu_wdat_i,
    output logic             cpu_ready_o,
    output logic      [15:0] cpu_rdat_o,
    output logic             arb_slot_ok_o,
    output logic      [18:0] mem_adr_o,
    output logic      [15:0] mem_dat_o,
    output logic             mem_dat_oe_o,
    input  wire logic [15:0] mem_dat_i,
    output logic             mem_rd_n_o,
    output logic             mem_wr_n_o,
    output logic             mem_byte_mode_o,
    output logic             extended_space_chip_select_n_o,
    output logic             ram_chip_select_n_o,
    output logic             rom_chip_select_n_o
);
    logic [15:0] page_one_reg;
    logic [15:0] page_two_reg;
    logic        upper_en_reg;
    logic [15:0] timing_reg;
    logic [2:0]  arb_reg;
    logic        echo_reg;
    logic        ack_reg;
    logic [2:0]  slot_reg;
    mem_state_t  state_reg;
    logic [2:0]  wait_reg;
    logic [1:0]  region_reg;   // 0 extended, 1 rom, 2 ram
    logic        page_sel_reg;
    logic [15:0] cpu_adr_reg;
    logic [15:0] wdat_reg;
    logic        we_reg;
    logic [15:0] rdat_reg;
    logic        ready_reg;

    function automatic logic [15:0] lanes(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] sel, input logic [15:0] msk);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) r[7:0] = new_v[7:0];
        if (sel[1]) r[15:8] = new_v[15:8];
        return r & msk;
    endfunction

    // region codes carried from decode into the strobe phase
    localparam logic [1:0] REGION_EXT = 2'd0;
    localparam logic [1:0] REGION_ROM = 2'd1;
    localparam logic [1:0] REGION_RAM = 2'd2;

    // everything below the page windows and the rom base falls to ram
    function automatic logic [1:0] region_of(input logic [15:0] adr);
        logic [1:0] r;
        r = REGION_RAM;
        if (adr[15:13] == PAGE_TAG || adr[15:13] == PAGE2_TAG) begin
            r = REGION_EXT;
        end else if (adr >= ROM_BASE) begin
            r = REGION_ROM;
        end
        return r;
    endfunction

    function automatic logic [2:0] region_wait(input logic [15:0] tim, input logic [1:0] rgn);
        logic [2:0] r;
        case (rgn)
            REGION_EXT: r = tim[EXT_WAIT_LSB +: 3];
            REGION_ROM: r = tim[ROM_WAIT_LSB +: 3];
            default:    r = tim[RAM_WAIT_LSB +: 3];
        endcase
        return r;
    endfunction

    function automatic logic region_width(input logic [15:0] tim, input logic [1:0] rgn);
        logic r;
        case (rgn)
            REGION_EXT: r = tim[EXT_WIDTH_BIT];
            REGION_ROM: r = tim[ROM_WIDTH_BIT];
            default:    r = tim[RAM_WIDTH_BIT];
        endcase
        return r;
    endfunction

    logic wb_hit;
    logic wb_wr;
    assign wb_hit = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr  = wb_hit && wb_we_i;
    assign wb_ack_o = ack_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ack_reg  <= 1'b0;
            wb_dat_o <= ZERO16;
        end else begin
            ack_reg <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    PAGE_ONE_OFS: wb_dat_o <= page_one_reg;
                    PAGE_TWO_OFS: wb_dat_o <= page_two_reg;
                    UPPER_EN_OFS: wb_dat_o <= {12'h000, upper_en_reg, 3'h0};
                    TIMING_OFS:   wb_dat_o <= timing_reg;
                    STATUS_OFS:   wb_dat_o <= {12'h000, state_reg};
                    default:      wb_dat_o <= ZERO16;
                endcase
            end
        end
    end

    // reserved bits are masked off on write; software should write zero anyway
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            page_one_reg <= ZERO16;
            page_two_reg <= ZERO16;
            upper_en_reg <= 1'b0;
            timing_reg   <= TIMING_RST;
            arb_reg      <= WAIT_ZERO;
            echo_reg     <= 1'b0;
        end else if (wb_wr) begin
            case (wb_adr_i)
                PAGE_ONE_OFS: page_one_reg <= lanes(page_one_reg, wb_dat_i, wb_sel_i, 16'hFFFF);
                PAGE_TWO_OFS: page_two_reg <= lanes(page_two_reg, wb_dat_i, wb_sel_i, 16'hFFFF);
                UPPER_EN_OFS: upper_en_reg <= wb_sel_i[0] ? wb_dat_i[UPPER_EN_BIT] : upper_en_reg;
                TIMING_OFS:   timing_reg <= lanes(timing_reg, wb_dat_i, wb_sel_i, TIMING_MASK);
                MEMTEST_OFS: begin
                    if (wb_sel_i[1]) arb_reg <= wb_dat_i[ARB_LSB +: 3];
                    if (wb_sel_i[0]) echo_reg <= wb_dat_i[ECHO_BIT];
                end
                default: ;
            endcase
        end
    end

    // eight-slot wheel; slots below k are dead
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) slot_reg <= WAIT_ZERO;
        else slot_reg <= slot_reg + SLOT_ONE;
    end
    assign arb_slot_ok_o = (slot_reg >= arb_reg);

    logic       hit_page2;
    logic [1:0] region_next;
    logic [2:0] wait_next;
    assign hit_page2   = cpu_adr_i[15:13] == PAGE2_TAG;
    assign region_next = region_of(cpu_adr_i);
    // wait field per region
    assign wait_next   = region_wait(timing_reg, region_next);

    // select held through setup and strobe; registered address valid one cycle later, from strobe into done; waits stretch strobe
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state_reg    <= ST_IDLE;
            wait_reg     <= WAIT_ZERO;
            region_reg   <= 2'd2;
            page_sel_reg <= 1'b0;
            cpu_adr_reg  <= ZERO16;
            wdat_reg     <= ZERO16;
            we_reg       <= 1'b0;
            rdat_reg     <= ZERO16;
            ready_reg    <= 1'b0;
        end else begin
            ready_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: if (cpu_req_i && arb_slot_ok_o) begin
                    state_reg    <= ST_SETUP;
                    region_reg   <= region_next;
                    page_sel_reg <= hit_page2;
                    wait_reg     <= wait_next;
                    cpu_adr_reg  <= cpu_adr_i;
                    wdat_reg     <= cpu_wdat_i;
                    we_reg       <= cpu_we_i;
                end
                ST_SETUP: state_reg <= ST_STROBE;
                ST_STROBE: begin
                    // one system clock per wait state
                    if (wait_reg == WAIT_ZERO) begin
                        state_reg <= ST_DONE;
                        rdat_reg  <= mem_dat_i;
                        ready_reg <= 1'b1;
                    end else begin
                        wait_reg <= wait_reg - SLOT_ONE;
                    end
                end
                ST_DONE: if (!cpu_req_i) state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    logic        active;
    logic        strobe;
    logic        ext_sel;
    logic [15:0] page_val;
    logic [18:0] adr_c;
    assign active   = (state_reg == ST_SETUP) || (state_reg == ST_STROBE);
    assign strobe   = state_reg == ST_STROBE;
    assign ext_sel  = active && region_reg == REGION_EXT;
    assign page_val = page_sel_reg ? page_two_reg : page_one_reg;

    always_comb begin
        adr_c = {UPPER_IDLE, cpu_adr_reg[14:0]};
        if (ext_sel) begin
            adr_c = {UPPER_IDLE, 2'b00, cpu_adr_reg[12:0]};
            // page bits onto the low address pins
            // sram mode narrows the page to five pins at the bottom of the bus
            if (sram_mode_i) begin
                adr_c[4:0] = page_val[4:0];
            end else begin
                adr_c[8:0] = page_val[8:0];
            end
        end
        // A18..A15 stay high whether enabled or not
        if (!upper_en_reg) adr_c[18:15] = UPPER_IDLE;
        if (echo_reg) adr_c = {3'h0, cpu_adr_i};
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) mem_adr_o <= {UPPER_IDLE, 15'h0000};
        else mem_adr_o <= adr_c;
    end

    logic byte_c;
    assign byte_c = region_width(timing_reg, region_reg);

    assign mem_byte_mode_o = byte_c;
    assign mem_dat_o       = wdat_reg;
    assign mem_dat_oe_o    = active && we_reg;
    assign mem_rd_n_o      = !(strobe && !we_reg);
    assign mem_wr_n_o      = !(strobe && we_reg);
    assign extended_space_chip_select_n_o = !ext_sel;
    // merged selects follow the extended select
    assign ram_chip_select_n_o = !((active && region_reg == REGION_RAM)
                                   || (ext_sel && timing_reg[RAM_MERGE_BIT]));
    assign rom_chip_select_n_o = !((active && region_reg == REGION_ROM)
                                   || (ext_sel && timing_reg[ROM_MERGE_BIT]));
    assign cpu_ready_o = ready_reg;
    assign cpu_rdat_o  = rdat_reg;
endmodule
`default_nettype wire

// ### verif/ext_mem_asserts.sv
// pin-level assertions for the external memory port control
`timescale 1ns/1ps
`default_nettype none
module ext_mem_asserts (
    input wire logic        clk_sys_i,
    input wire logic        nrst_i,
    input wire logic [15:0] cpu_adr_i,
    input wire logic        arb_slot_ok_o,
    input wire logic [18:0] mem_adr_o,
    input wire logic        mem_rd_n_o,
    input wire logic        mem_wr_n_o,
    input wire logic        extended_space_chip_select_n_o,
    input wire logic        ram_chip_select_n_o,
    input wire logic        rom_chip_select_n_o
);
    wire        strb = !mem_rd_n_o || !mem_wr_n_o;
    logic [3:0] dead_cnt;
    logic [3:0] strb_cnt;
    always_ff @(posedge clk_sys_i) begin
        dead_cnt <= (!nrst_i || arb_slot_ok_o) ? 4'h0 : dead_cnt + 4'h1;
    end
    always_ff @(posedge clk_sys_i) begin
        strb_cnt <= (!nrst_i || !strb) ? 4'h0 : strb_cnt + 4'h1;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    AST_UPPER_IDLE: assert property ($rose(nrst_i) |-> mem_adr_o[18:15] == 4'hF)
        else $error("upper address lines not high after reset");
    AST_ARB_LIVE: assert property (dead_cnt < 4'h8)
        else $error("eight dead arbitration slots in a row");
    AST_WAIT_MAX: assert property (strb |-> strb_cnt < 4'h8)
        else $error("strobe longer than eight cycles");
    AST_STROBE_SELECT: assert property (strb |-> !(extended_space_chip_select_n_o
        && ram_chip_select_n_o && rom_chip_select_n_o)) else $error("strobe without select");
    AST_ADR_HOLD: assert property (strb && $past(strb) |-> $stable(mem_adr_o))
        else $error("address moved during strobe");
    AST_PAGE_SELECT: assert property (strb && cpu_adr_i[15:14] == 2'b10
        |-> !extended_space_chip_select_n_o) else $error("page access without extended select");
    AST_ROM_SELECT: assert property (strb && cpu_adr_i[15:14] == 2'b11
        |-> !rom_chip_select_n_o && extended_space_chip_select_n_o) else $error("rom select wrong");
    AST_RAM_SELECT: assert property (strb && !cpu_adr_i[15]
        |-> !ram_chip_select_n_o && extended_space_chip_select_n_o) else $error("ram select wrong");
endmodule
bind external_memory_port_control ext_mem_asserts u_chk (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cpu_adr_i(cpu_adr_i), .arb_slot_ok_o(arb_slot_ok_o),
    .mem_adr_o(mem_adr_o), .mem_rd_n_o(mem_rd_n_o), .mem_wr_n_o(mem_wr_n_o),
    .extended_space_chip_select_n_o(extended_space_chip_select_n_o),
    .ram_chip_select_n_o(ram_chip_select_n_o), .rom_chip_select_n_o(rom_chip_select_n_o));
`default_nettype wire

// ### verif/ext_sram_model.sv
// behavioural external sram on the memory port
`timescale 1ns/1ps
`default_nettype none
module ext_sram_model (
    input  wire logic        clk_sys_i,
    input  wire logic [18:0] mem_adr_i,
    input  wire logic [15:0] mem_dat_i,
    input  wire logic        mem_rd_n_i,
    input  wire logic        mem_wr_n_i,
    output logic      [15:0] mem_dat_o
);
    logic [15:0] mem [logic [18:0]];
    logic [15:0] last = 16'h0000;
    always @(posedge clk_sys_i) begin
        if (!mem_wr_n_i) mem[mem_adr_i] = mem_dat_i;
        if (!mem_rd_n_i) last <= mem_dat_o;
    end
    // released bus shows the inverse so stale data cannot pass
    assign mem_dat_o = (!mem_rd_n_i && mem.exists(mem_adr_i)) ? mem[mem_adr_i] : ~last;
endmodule
`default_nettype wire

// ### verif/external_memory_port_control_test.sv
// self-checking bench for external memory port control
`timescale 1ns/1ps
`default_nettype none
module external_memory_port_control_test;
    import ext_mem_pkg::*;
    logic clk_sys_i = 0, nrst_i = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, sram_mode_i = 0;
    logic cpu_req_i = 0, cpu_we_i = 0, wb_ack_o, cpu_ready_o, arb_slot_ok_o, mem_dat_oe_o;
    logic mem_rd_n_o, mem_wr_n_o, mem_byte_mode_o, xs_n, ra_n, ro_n, s, s_d = 0, b, sm;
    logic [15:0] wb_adr_i = 0, wb_dat_i = 0, cpu_adr_i = 0, cpu_wdat_i = 0, wb_dat_o, cpu_rdat_o;
    logic [15:0] mem_dat_o, mem_dat_i, t, a, d, pg[2];
    logic [18:0] mem_adr_o, m;
    logic [2:0]  c, w;
    logic [31:0] rq[$], wq[$], e;
    logic [63:0] aq[$], f;
    logic [15:0] ra[6] = '{PAGE_ONE_OFS, PAGE_TWO_OFS, UPPER_EN_OFS, TIMING_OFS, MEMTEST_OFS, 16'hC030};
    logic [15:0] rm[6] = '{16'hFFFF, 16'hFFFF, UPPER_MASK, TIMING_MASK, 16'h0000, 16'h0000};
    int seed = 32'h5908, n_mismatch = 0, cmp_count = 0, cyc_cnt = 0, n = 0, r;
    always #12.5 clk_sys_i = ~clk_sys_i;
    external_memory_port_control DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
        .wb_sel_i(2'b11), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .sram_mode_i(sram_mode_i), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
        .cpu_adr_i(cpu_adr_i), .cpu_wdat_i(cpu_wdat_i), .cpu_ready_o(cpu_ready_o),
        .cpu_rdat_o(cpu_rdat_o), .arb_slot_ok_o(arb_slot_ok_o), .mem_adr_o(mem_adr_o),
        .mem_dat_o(mem_dat_o), .mem_dat_oe_o(mem_dat_oe_o), .mem_dat_i(mem_dat_i),
        .mem_rd_n_o(mem_rd_n_o), .mem_wr_n_o(mem_wr_n_o), .mem_byte_mode_o(mem_byte_mode_o),
        .extended_space_chip_select_n_o(xs_n), .ram_chip_select_n_o(ra_n),
        .rom_chip_select_n_o(ro_n));
    ext_sram_model u_mem (.clk_sys_i(clk_sys_i), .mem_adr_i(mem_adr_o), .mem_dat_i(mem_dat_o),
        .mem_rd_n_i(mem_rd_n_o), .mem_wr_n_i(mem_wr_n_o), .mem_dat_o(mem_dat_i));
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task wb(input logic we, input logic [15:0] adr, input logic [15:0] dat);
        @(posedge clk_sys_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task cpu(input logic we, input logic [15:0] adr, input logic [15:0] dat);
        @(posedge clk_sys_i);
        {cpu_req_i, cpu_we_i, cpu_adr_i, cpu_wdat_i} <= {1'b1, we, adr, dat};
        do @(posedge clk_sys_i); while (cpu_ready_o !== 1'b1);
        cpu_req_i <= 1'b0;
    endtask
    // monitor takes the oldest note whenever a result shows
    always @(posedge clk_sys_i) begin
        if (++cyc_cnt == 20000) begin n_mismatch++; summarize(); end
        s = !mem_rd_n_o || !mem_wr_n_o;
        if (wb_ack_o === 1'b1 && !wb_we_i) begin e = rq.pop_front(); cmp(wb_dat_o & e[31:16], e[15:0]); end
        if (cpu_ready_o === 1'b1 && !cpu_we_i) begin
            e = rq.pop_front();
            cmp(cpu_rdat_o & e[31:16], e[15:0]);
        end
        if (s && !s_d) begin
            f = aq.pop_front();
            cmp({mem_byte_mode_o, xs_n, ra_n, ro_n, mem_adr_o} & f[63:32], f[31:0]);
        end
        if (s) n++;
        else if (s_d) begin cmp(n, wq.pop_front()); n = 0; end
        s_d = s;
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rq.push_back({16'hFFFF, 16'h0000});
            wb(1'b0, ra[i], 16'h0000);
            d = $random(seed) & rm[i];
            rq.push_back({16'hFFFF, d});
            wb(1'b1, ra[i], d);
            wb(1'b0, ra[i], 16'h0000);
        end
        wb(1'b1, UPPER_EN_OFS, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, MEMTEST_OFS, 16'(k << ARB_LSB));
            r = 0;
            repeat (8) begin @(posedge clk_sys_i); r += (arb_slot_ok_o === 1'b1); end
            cmp(r, 8 - k);
        end
        wb(1'b1, MEMTEST_OFS, 16'h0001);
        a = $random(seed);
        cpu_adr_i <= a;
        repeat (3) @(posedge clk_sys_i);
        cmp(mem_adr_o[15:0], a);
        wb(1'b1, MEMTEST_OFS, 16'h0000);
        repeat (2) @(posedge clk_sys_i);
        cmp(mem_adr_o[18:15], 4'hF);
        for (int i = 0; i < 24; i++) begin
            t = $random(seed) & TIMING_MASK;
            pg[0] = $random(seed) & 16'hFEFF;
            pg[1] = $random(seed) & 16'hFEFF;
            wb(1'b1, TIMING_OFS, t);
            wb(1'b1, PAGE_ONE_OFS, pg[0]);
            wb(1'b1, PAGE_TWO_OFS, pg[1]);
            sm = $random(seed);
            sram_mode_i <= sm;
            r = i % 4;
            a = $random(seed);
            a[15:13] = (r < 2) ? PAGE_TAG + 3'(r) : (r == 2) ? {2'b11, a[13]} : {1'b0, a[14:13]};
            c = (r < 2) ? {1'b0, ~t[RAM_MERGE_BIT], ~t[ROM_MERGE_BIT]} : (r == 2) ? 3'b110 : 3'b101;
            w = (r < 2) ? t[10:8] : (r == 2) ? t[6:4] : t[2:0];
            b = (r < 2) ? t[EXT_WIDTH_BIT] : (r == 2) ? t[ROM_WIDTH_BIT] : t[RAM_WIDTH_BIT];
            m = (r > 1) ? 19'h78000 : sm ? 19'h7801F : 19'h781FF;
            d = $random(seed);
            for (int we = 1; we >= 0; we--) begin
                aq.push_back({9'h0, 4'hF, m, 9'h0, b, c, (19'h78000 | 19'(pg[r & 1])) & m});
                wq.push_back(32'(w) + 1);
                if (we == 0) rq.push_back({b ? 16'h00FF : 16'hFFFF, d & (b ? 16'h00FF : 16'hFFFF)});
                cpu(1'(we), a, d);
            end
        end
        repeat (4) @(posedge clk_sys_i);
        summarize();
    end
endmodule
`default_nettype wire
